/* File: cfg_requester.sv */
// Requester model issuing word accesses on the configuration port
`timescale 1ns/1ps
module cfg_requester (
    input  wire logic        ref_clk_i,
    output logic             req_o,
    output logic             write_o,
    output logic             reply_o,
    output logic [3:0]       addr_o,
    output logic [31:0]      wdata_o,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [3:0]  status_i
);
    initial begin
        {req_o, write_o, reply_o, addr_o, wdata_o} = '0;
    end

    // One request per call, answer awaited a few cycles; a wipe write asks no reply
    task automatic xfer(input logic w, input logic rp, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic [3:0] st, output logic ok);
        {ok, rd, st} = {1'b0, 32'hFFFF_FFFF, 4'hF};
        @(posedge ref_clk_i);
        {req_o, write_o, reply_o, addr_o, wdata_o} <= {1'b1, w, rp, a, d};
        @(posedge ref_clk_i);
        req_o <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge ref_clk_i);
            if (ack_i === 1'b1) {ok, rd, st} = {1'b1, rdata_i, status_i};
        end
        // Stale address and data are inverted so nothing leans on old values
        {addr_o, wdata_o} <= ~{addr_o, wdata_o};
    endtask : xfer
endmodule : cfg_requester

/* File: router_cfg_pkg.sv */
// Shared constants, register indices and state types of the router global configuration block
package router_cfg_pkg;

    localparam int NPORTS = 8;

    // Register indices on the configuration port
    localparam logic [3:0] IDX_CFG_STATUS = 4'h0;
    localparam logic [3:0] IDX_TIME_CODE  = 4'h1;
    localparam logic [3:0] IDX_VERSION    = 4'h2;
    localparam logic [3:0] IDX_INIT_DIV   = 4'h3;
    localparam logic [3:0] IDX_WR_LOCK    = 4'h4;
    localparam logic [3:0] IDX_TICK_DIV   = 4'h5;
    localparam logic [3:0] IDX_PORT_BASE  = 4'h8;

    // Bit positions
    localparam int BIT_WIPE        = 7;
    localparam int BIT_AUTO_STOP   = 6;
    localparam int BIT_LINK_DEMAND = 5;
    localparam int BIT_LOOPBACK    = 4;
    localparam int BIT_FLAG_CHECK  = 3;
    localparam int BIT_RAM_FAULT   = 2;
    localparam int BIT_TC_WIPE     = 9;
    localparam int BIT_TC_ENABLE   = 8;
    localparam int BIT_WR_ALLOW    = 0;

    // Capability and identity fields; version numbers are arbitrary
    localparam logic [4:0] LINK_COUNT        = 5'h08;
    localparam logic [4:0] BUS_SIDE_COUNT    = 5'h04;
    localparam logic [4:0] FIFO_SIDE_COUNT   = 5'h00;
    localparam logic       TIMERS_PRESENT    = 1'b1;
    localparam logic       DISCOVERY_PRESENT = 1'b1;
    localparam logic [7:0] VER_MAJOR         = 8'h01;
    localparam logic [7:0] VER_MINOR         = 8'h00;
    localparam logic [7:0] VER_PATCH         = 8'h00;

    // Reset values and counts
    localparam logic [7:0]  UNIT_BASE       = 8'h40;
    localparam logic [7:0]  INIT_DIV_RST    = 8'h13;
    localparam logic [15:0] TICK_DIV_RST    = 16'h00FA;
    localparam logic [9:0]  PORT_RELOAD_RST = 10'h3FF;
    localparam logic [9:0]  PORT_RELOAD_MIN = 10'h001;
    localparam logic [2:0]  WIPE_CYCLES     = 3'h7;

    // Answer status codes
    localparam logic [3:0] STATUS_OK       = 4'h0;
    localparam logic [3:0] STATUS_BAD_ADDR = 4'h1;
    localparam logic [3:0] STATUS_AUTH     = 4'hA;

    typedef struct packed {
        logic [2:0]              wipe_cnt;
        logic                    wipe_o;
        logic                    strap_load;
        logic                    auto_stop;
        logic                    link_demand;
        logic                    loopback;
        logic                    flag_check;
        logic                    ram_fault;
        logic                    tc_enable;
        logic [1:0]              tc_flags;
        logic [5:0]              tc_count;
        logic                    tc_valid;
        logic [7:0]              unit_num;
        logic [7:0]              init_div;
        logic                    wr_allow;
        logic [15:0]             tick_div;
        logic [NPORTS-1:0][9:0]  reload;
        logic [NPORTS-1:0][9:0]  timer;
        logic [NPORTS-1:0]       link_start;
        logic [NPORTS-1:0]       port_stop;
        logic                    discard;
        logic                    ack;
        logic [31:0]             rdata;
        logic [3:0]              status;
    } router_state_t;

    localparam router_state_t ROUTER_RST = '{
        wipe_cnt: 3'h0, wipe_o: 1'b0, strap_load: 1'b1, auto_stop: 1'b0,
        link_demand: 1'b0, loopback: 1'b0, flag_check: 1'b0, ram_fault: 1'b0,
        tc_enable: 1'b1, tc_flags: 2'h0, tc_count: 6'h00, tc_valid: 1'b0,
        unit_num: UNIT_BASE, init_div: INIT_DIV_RST, wr_allow: 1'b1,
        tick_div: TICK_DIV_RST, reload: {NPORTS{PORT_RELOAD_RST}},
        timer: {NPORTS{PORT_RELOAD_RST}}, link_start: '0, port_stop: '0,
        discard: 1'b0, ack: 1'b0, rdata: 32'h0000_0000, status: STATUS_OK
    };

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } prescaler_state_t;

endpackage : router_cfg_pkg

/* File: router_global_cfg.sv */
// Global configuration and status registers of the eight-port packet router
// Behaviour
// - Wipe bit resets router, accesses ignored briefly
// - Auto stop idle ports after timeout
// - Pending transmit starts enabled link on demand
// - Self-addressed packets discarded unless loopback permitted
// - Optionally discard time-codes with nonzero flags
// - Memory fault flag set by error, writing a one clears
// - Timer and discovery capability bits read one
// - Report FIFO port count; reserved bits
// - Tick counter wipe zeroes flags, reads zero
// - Time-code propagate enable, resets to one
// - Time-code word shows flags and counter
// - Version word shows major, minor, patch
// - Unit number resets to base plus straps
// - Shared eight-bit link init rate divisor
// - Write lock rejects writes except lock register
// - Rejected write answered with authorization error when a reply is asked, else with OK status
// - Prescaler tick every divider plus one cycles
// - Report link and bus port counts
// - Port timeout counts ticks, zero stores one
`timescale 1ns/1ps
module router_global_cfg
    import router_cfg_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [1:0]        strap_i,
    // Configuration port
    input  wire logic              cfg_req_i,
    input  wire logic              cfg_write_i,
    input  wire logic              cfg_reply_i,
    input  wire logic [3:0]        cfg_addr_i,
    input  wire logic [31:0]       cfg_wdata_i,
    output logic                   cfg_ack_o,
    output logic [31:0]            cfg_rdata_o,
    output logic [3:0]             cfg_status_o,
    // Router-wide controls
    output logic                   router_wipe_o,
    output logic [7:0]             init_rate_divisor_o,
    // Port activity and links
    input  wire logic [NPORTS-1:0] port_active_i,
    input  wire logic [NPORTS-1:0] tx_request_i,
    input  wire logic [NPORTS-1:0] link_disabled_i,
    output logic [NPORTS-1:0]      link_start_o,
    output logic [NPORTS-1:0]      port_stop_o,
    // Routing address check
    input  wire logic              route_valid_i,
    input  wire logic [2:0]        route_src_i,
    input  wire logic [2:0]        route_dst_i,
    output logic                   self_addr_discard_o,
    // Memory error report
    input  wire logic              table_err_i,
    // Received time-codes
    input  wire logic              tc_in_valid_i,
    input  wire logic [1:0]        tc_in_flags_i,
    input  wire logic [5:0]        tc_in_count_i,
    output logic                   tc_valid_o,
    output logic [1:0]             tc_flags_o,
    output logic [5:0]             tc_count_o
);

    router_state_t s_r;
    router_state_t s_nxt;

    tick_if u_tick_if ();

    tick_prescaler u_prescaler (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .tk        (u_tick_if.producer)
    );

    assign u_tick_if.divider = s_r.tick_div;

    logic       idle;
    logic       is_port;
    logic [2:0] port_idx;
    logic       locked_out;
    assign idle       = (s_r.wipe_cnt == 3'h0);
    assign is_port    = (cfg_addr_i >= IDX_PORT_BASE);
    assign port_idx   = cfg_addr_i[2:0];
    assign locked_out = cfg_write_i && !s_r.wr_allow && (cfg_addr_i != IDX_WR_LOCK);

    // Next-state: wipe sequence, configuration port, then hardware events
    always_comb begin
        s_nxt            = s_r;
        s_nxt.ack        = 1'b0;
        s_nxt.status     = STATUS_OK;
        s_nxt.tc_valid   = 1'b0;
        s_nxt.discard    = 1'b0;
        s_nxt.link_start = '0;
        s_nxt.port_stop  = '0;
        if (!idle) begin
            // Block held at reset values except the wipe counter and wipe output; requests are not answered
            s_nxt          = ROUTER_RST;
            s_nxt.wipe_cnt = s_r.wipe_cnt - 3'h1;
            s_nxt.wipe_o   = (s_r.wipe_cnt != 3'h1);
        end else begin
            // Straps are caught after reset release, never under the async reset
            if (s_r.strap_load) begin
                s_nxt.unit_num   = UNIT_BASE + {6'h00, strap_i};
                s_nxt.strap_load = 1'b0;
            end
            if (cfg_req_i) begin
                s_nxt.ack   = 1'b1;
                s_nxt.rdata = 32'h0000_0000;
                if (!cfg_write_i) begin
                    // Reserved bits read zero; wipe and tick-wipe bits read zero
                    if (is_port) begin
                        s_nxt.rdata = {22'h000000, s_r.reload[port_idx]};
                    end else begin
                        unique case (cfg_addr_i)
                            IDX_CFG_STATUS: s_nxt.rdata = {LINK_COUNT, BUS_SIDE_COUNT,
                                FIFO_SIDE_COUNT, 9'h000, 1'b0, s_r.auto_stop,
                                s_r.link_demand, s_r.loopback, s_r.flag_check,
                                s_r.ram_fault, TIMERS_PRESENT, DISCOVERY_PRESENT};
                            IDX_TIME_CODE:  s_nxt.rdata = {22'h000000, 1'b0, s_r.tc_enable,
                                s_r.tc_flags, s_r.tc_count};
                            IDX_VERSION:    s_nxt.rdata = {VER_MAJOR, VER_MINOR, VER_PATCH, s_r.unit_num};
                            IDX_INIT_DIV:   s_nxt.rdata = {24'h000000, s_r.init_div};
                            IDX_WR_LOCK:    s_nxt.rdata = {31'h00000000, s_r.wr_allow};
                            IDX_TICK_DIV:   s_nxt.rdata = {16'h0000, s_r.tick_div};
                            default:        s_nxt.status = STATUS_BAD_ADDR;
                        endcase
                    end
                end else if (locked_out) begin
                    // Rejected write leaves every register untouched
                    s_nxt.status = cfg_reply_i ? STATUS_AUTH : STATUS_OK;
                end else if (is_port) begin
                    s_nxt.reload[port_idx] = (cfg_wdata_i[9:0] == 10'h000) ? PORT_RELOAD_MIN
                                                                         : cfg_wdata_i[9:0];
                end else begin
                    unique case (cfg_addr_i)
                        IDX_CFG_STATUS: begin
                            s_nxt.auto_stop   = cfg_wdata_i[BIT_AUTO_STOP];
                            s_nxt.link_demand = cfg_wdata_i[BIT_LINK_DEMAND];
                            s_nxt.loopback    = cfg_wdata_i[BIT_LOOPBACK];
                            s_nxt.flag_check  = cfg_wdata_i[BIT_FLAG_CHECK];
                            if (cfg_wdata_i[BIT_RAM_FAULT]) begin
                                s_nxt.ram_fault = 1'b0;
                            end
                            if (cfg_wdata_i[BIT_WIPE]) begin
                                s_nxt.wipe_cnt = WIPE_CYCLES;
                                s_nxt.wipe_o   = 1'b1;
                            end
                        end
                        IDX_TIME_CODE: begin
                            s_nxt.tc_enable = cfg_wdata_i[BIT_TC_ENABLE];
                            if (cfg_wdata_i[BIT_TC_WIPE]) begin
                                s_nxt.tc_flags = 2'h0;
                                s_nxt.tc_count = 6'h00;
                            end
                        end
                        IDX_VERSION:  s_nxt.unit_num = cfg_wdata_i[7:0];
                        IDX_INIT_DIV: s_nxt.init_div = cfg_wdata_i[7:0];
                        IDX_WR_LOCK:  s_nxt.wr_allow = cfg_wdata_i[BIT_WR_ALLOW];
                        // No clamp here: keeping it at or above 250 is software's duty
                        IDX_TICK_DIV: s_nxt.tick_div = cfg_wdata_i[15:0];
                        default:      s_nxt.status   = STATUS_BAD_ADDR;
                    endcase
                end
            end
            // Hardware events come after software clears so the set wins
            if (table_err_i) begin
                s_nxt.ram_fault = 1'b1;
            end
            if (s_r.tc_enable && tc_in_valid_i &&
                (!s_r.flag_check || (tc_in_flags_i == 2'h0))) begin
                s_nxt.tc_flags = tc_in_flags_i;
                s_nxt.tc_count = tc_in_count_i;
                s_nxt.tc_valid = 1'b1;
            end
            s_nxt.link_start = s_r.link_demand ? (tx_request_i & ~link_disabled_i) : '0;
            s_nxt.discard    = route_valid_i && !s_r.loopback && (route_src_i == route_dst_i);
            // Per-port inactivity timers run on the common tick
            for (int p = 0; p < NPORTS; p++) begin
                if (port_active_i[p]) begin
                    s_nxt.timer[p] = s_r.reload[p];
                end else if (u_tick_if.tick && (s_r.timer[p] != 10'h000)) begin
                    s_nxt.timer[p] = s_r.timer[p] - 10'h001;
                    s_nxt.port_stop[p] = (s_r.timer[p] == 10'h001) && s_r.auto_stop && TIMERS_PRESENT;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= ROUTER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign cfg_ack_o           = s_r.ack;
    assign cfg_rdata_o         = s_r.rdata;
    assign cfg_status_o        = s_r.status;
    assign router_wipe_o       = s_r.wipe_o;
    assign init_rate_divisor_o = s_r.init_div;
    assign link_start_o        = s_r.link_start;
    assign port_stop_o         = s_r.port_stop;
    assign self_addr_discard_o = s_r.discard;
    assign tc_valid_o          = s_r.tc_valid;
    assign tc_flags_o          = s_r.tc_flags;
    assign tc_count_o          = s_r.tc_count;

    // Helper: which register the last read addressed
    logic       rd_q;
    logic [3:0] rd_idx_q;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q     <= 1'b0;
            rd_idx_q <= 4'h0;
        end else begin
            rd_q     <= cfg_req_i && !cfg_write_i && idle;
            rd_idx_q <= cfg_addr_i;
        end
    end

    property p_wipe_hold;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(router_wipe_o) |-> router_wipe_o[*7] ##1 !router_wipe_o;
    endproperty
    a_wipe_hold: assert property (p_wipe_hold) else $error("wipe not held for seven cycles");

    property p_wipe_ignore;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        router_wipe_o |=> !cfg_ack_o;
    endproperty
    a_wipe_ignore: assert property (p_wipe_ignore) else $error("request answered during wipe");

    property p_wipe_reads_zero;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (rd_q && (rd_idx_q == IDX_CFG_STATUS)) |-> !cfg_rdata_o[BIT_WIPE];
    endproperty
    a_wipe_reads_zero: assert property (p_wipe_reads_zero) else $error("wipe bit read as one");

    property p_tc_wipe_reads_zero;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (rd_q && (rd_idx_q == IDX_TIME_CODE)) |-> (cfg_rdata_o[31:BIT_TC_WIPE] == 23'h000000);
    endproperty
    a_tc_wipe_reads_zero: assert property (p_tc_wipe_reads_zero) else $error("time-code upper bits not zero");

    property p_link_demand;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && s_r.link_demand && tx_request_i[0] && !link_disabled_i[0]) |=> link_start_o[0];
    endproperty
    a_link_demand: assert property (p_link_demand) else $error("link not started on request");

    property p_self_addr;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && route_valid_i && (route_src_i == route_dst_i)) |=> (self_addr_discard_o == !$past(s_r.loopback));
    endproperty
    a_self_addr: assert property (p_self_addr) else $error("self-address discard wrong");

    property p_tc_filter;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && tc_in_valid_i && (s_r.flag_check && (tc_in_flags_i != 2'h0) || !s_r.tc_enable)) |=> !tc_valid_o;
    endproperty
    a_tc_filter: assert property (p_tc_filter) else $error("filtered time-code propagated");

    property p_tc_update;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && tc_in_valid_i && s_r.tc_enable && !s_r.flag_check) |=> tc_valid_o && (tc_count_o == $past(tc_in_count_i));
    endproperty
    a_tc_update: assert property (p_tc_update) else $error("time-code not taken");

    property p_ram_fault;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && table_err_i) |=> s_r.ram_fault;
    endproperty
    a_ram_fault: assert property (p_ram_fault) else $error("memory fault flag lost");

    property p_lock_auth;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && cfg_req_i && locked_out && cfg_reply_i) |=> cfg_ack_o && (cfg_status_o == STATUS_AUTH) && $stable(s_r.init_div);
    endproperty
    a_lock_auth: assert property (p_lock_auth) else $error("locked write not refused");

    property p_reload_min;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (idle && cfg_req_i && cfg_write_i && !locked_out && (cfg_addr_i == IDX_PORT_BASE) &&
         (cfg_wdata_i[9:0] == 10'h000)) |=> (s_r.reload[0] == PORT_RELOAD_MIN);
    endproperty
    a_reload_min: assert property (p_reload_min) else $error("zero timeout stored");

endmodule : router_global_cfg

/* File: router_global_cfg_bench.sv */
// Self-checking bench of the router global configuration registers
`timescale 1ns/1ps
module router_global_cfg_bench;
    import router_cfg_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [1:0]  strap = 2'h0;
    logic        req, wr, rpl, ack, wipe, rv = 1'b0, disc, err = 1'b0, tv = 1'b0, tvo;
    logic [3:0]  addr, st;
    logic [31:0] wd, rdat, v;
    logic [7:0]  idiv, act = 8'hFF, txr = 8'h00, ldis = 8'h00, lst, stp;
    logic [2:0]  src = 3'h0, dst = 3'h1;
    logic [1:0]  tf = 2'h0, tfo;
    logic [5:0]  tcn = 6'h00, tco;
    int          errors = 0, compares = 0, cycles = 0, n;

    always #4 ref_clk_i = ~ref_clk_i;

    cfg_requester host (.ref_clk_i(ref_clk_i), .req_o(req), .write_o(wr), .reply_o(rpl), .addr_o(addr),
                        .wdata_o(wd), .ack_i(ack), .rdata_i(rdat), .status_i(st));

    router_global_cfg dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .strap_i(strap), .cfg_req_i(req),
        .cfg_write_i(wr), .cfg_reply_i(rpl), .cfg_addr_i(addr), .cfg_wdata_i(wd), .cfg_ack_o(ack),
        .cfg_rdata_o(rdat), .cfg_status_o(st), .router_wipe_o(wipe), .init_rate_divisor_o(idiv),
        .port_active_i(act), .tx_request_i(txr), .link_disabled_i(ldis), .link_start_o(lst),
        .port_stop_o(stp), .route_valid_i(rv), .route_src_i(src), .route_dst_i(dst),
        .self_addr_discard_o(disc), .table_err_i(err), .tc_in_valid_i(tv), .tc_in_flags_i(tf),
        .tc_in_count_i(tcn), .tc_valid_o(tvo), .tc_flags_o(tfo), .tc_count_o(tco));

    // Expected status word from the control bits 7..2 and the fixed capability fields
    function automatic logic [31:0] cfg_word(input logic [7:0] c);
        return {LINK_COUNT, BUS_SIDE_COUNT, FIFO_SIDE_COUNT, 9'h000, c[7:2], TIMERS_PRESENT, DISCOVERY_PRESENT};
    endfunction : cfg_word

    task automatic results;
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One access and a check of answer, status and data (writes return zero data)
    task automatic acc(input logic w, input logic rp, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] es, input logic [31:0] ed);
        logic [31:0] r;
        logic [3:0]  s;
        logic        ok;
        host.xfer(w, rp, a, d, r, s, ok);
        chk({27'h0, ok, s}, {28'h0000001, es});
        chk(r, ed);
    endtask : acc

    task automatic tc(input logic [1:0] f, input logic [5:0] c, input logic e);
        @(posedge ref_clk_i);
        {tv, tf, tcn} <= {1'b1, f, c};
        @(posedge ref_clk_i);
        tv <= 1'b0;
        @(posedge ref_clk_i);
        chk({31'h0, tvo}, {31'h0, e});
        if (e) chk({24'h0, tfo, tco}, {24'h0, f, c});
    endtask : tc

    task automatic rt(input logic e);
        @(posedge ref_clk_i);
        {rv, src, dst} <= {1'b1, v[2:0], v[2:0]};
        @(posedge ref_clk_i);
        rv <= 1'b0;
        @(posedge ref_clk_i);
        chk({31'h0, disc}, {31'h0, e});
    endtask : rt

    // Hang guard sized well above the longest sequence
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    initial begin
        void'($urandom(47));
        v = $urandom;
        strap = v[1:0];
        repeat (6) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        acc(0, 1, IDX_CFG_STATUS, 0, STATUS_OK, cfg_word(8'h00));
        acc(0, 1, IDX_TIME_CODE, 0, STATUS_OK, 32'h0000_0100);
        acc(0, 1, IDX_VERSION, 0, STATUS_OK, {VER_MAJOR, VER_MINOR, VER_PATCH, UNIT_BASE + {6'h00, v[1:0]}});
        acc(0, 1, IDX_INIT_DIV, 0, STATUS_OK, 32'h0000_0013);
        acc(0, 1, 4'h6, 0, STATUS_BAD_ADDR, 32'h0000_0000);
        // Time-code filtering, enable and wipe
        v = $urandom;
        acc(1, 1, IDX_CFG_STATUS, 32'h0000_0008, STATUS_OK, 0);
        tc(2'h1, v[5:0], 1'b0);
        tc(2'h0, v[5:0], 1'b1);
        acc(0, 1, IDX_TIME_CODE, 0, STATUS_OK, {24'h000001, 2'h0, v[5:0]});
        acc(1, 1, IDX_CFG_STATUS, 32'h0000_0000, STATUS_OK, 0);
        tc(2'h3, v[11:6], 1'b1);
        acc(1, 1, IDX_TIME_CODE, 32'h0000_0000, STATUS_OK, 0);
        tc(2'h0, v[17:12], 1'b0);
        acc(1, 1, IDX_TIME_CODE, 32'h0000_0300, STATUS_OK, 0);
        acc(0, 1, IDX_TIME_CODE, 0, STATUS_OK, 32'h0000_0100);
        // Link start on demand, then self-addressing with and without permission
        acc(1, 1, IDX_CFG_STATUS, 32'h0000_0020, STATUS_OK, 0);
        {txr, ldis} <= v[31:16];
        repeat (3) @(posedge ref_clk_i);
        chk({24'h0, lst}, {24'h0, v[31:24] & ~v[23:16]});
        rt(1'b1);
        acc(1, 1, IDX_CFG_STATUS, 32'h0000_0030, STATUS_OK, 0);
        rt(1'b0);
        // Memory fault set by error, cleared by a one written
        err <= 1'b1;
        @(posedge ref_clk_i);
        err <= 1'b0;
        acc(0, 1, IDX_CFG_STATUS, 0, STATUS_OK, cfg_word(8'h34));
        acc(1, 1, IDX_CFG_STATUS, 32'h0000_0034, STATUS_OK, 0);
        acc(0, 1, IDX_CFG_STATUS, 0, STATUS_OK, cfg_word(8'h30));
        // Write lock refuses other registers but not itself
        acc(1, 1, IDX_WR_LOCK, 32'h0000_0000, STATUS_OK, 0);
        acc(1, 1, IDX_INIT_DIV, v, STATUS_AUTH, 0);
        acc(0, 1, IDX_INIT_DIV, 0, STATUS_OK, 32'h0000_0013);
        acc(1, 1, IDX_WR_LOCK, 32'h0000_0001, STATUS_OK, 0);
        acc(1, 1, IDX_INIT_DIV, v, STATUS_OK, 0);
        chk({24'h0, idiv}, {24'h0, v[7:0]});
        // Port 0 timeout: zero stores one, idle port stops within one tick period
        acc(1, 1, IDX_PORT_BASE, 32'h0000_0000, STATUS_OK, 0);
        acc(0, 1, IDX_PORT_BASE, 0, STATUS_OK, 32'h0000_0001);
        acc(1, 1, IDX_CFG_STATUS, 32'h0000_0040, STATUS_OK, 0);
        act <= 8'hFE;
        for (n = 0; n < 256 && stp !== 8'h01; n++) @(posedge ref_clk_i);
        chk({24'h0, stp}, 32'h0000_0001);
        // Requester keeps the tick divider at or above 250; read back what was written
        acc(1, 1, IDX_TICK_DIV, {16'h0000, 16'h00FA + {12'h000, v[3:0]}}, STATUS_OK, 0);
        acc(0, 1, IDX_TICK_DIV, 0, STATUS_OK, {16'h0000, 16'h00FA + {12'h000, v[3:0]}});
        // Router wipe: no reply asked, wipe output held seven cycles, registers back to reset
        acc(1, 0, IDX_CFG_STATUS, 32'h0000_0080, STATUS_OK, 0);
        for (n = 0; n < 12 && wipe === 1'b1; n++) @(posedge ref_clk_i);
        chk(n, {29'h0, WIPE_CYCLES});
        acc(0, 1, IDX_CFG_STATUS, 0, STATUS_OK, cfg_word(8'h00));
        acc(0, 1, IDX_INIT_DIV, 0, STATUS_OK, 32'h0000_0013);
        acc(0, 1, IDX_TICK_DIV, 0, STATUS_OK, {16'h0000, TICK_DIV_RST});
        results();
    end
endmodule : router_global_cfg_bench

/* File: tick_if.sv */
// Interface carrying the tick divider value and the common port-timer tick
`timescale 1ns/1ps
interface tick_if;
    logic [15:0] divider;
    logic        tick;

    modport producer (input divider, output tick);
    modport consumer (output divider, input tick);
endinterface : tick_if

/* File: tick_prescaler.sv */
// Global prescaler producing the common port-timer tick
`timescale 1ns/1ps
module tick_prescaler
    import router_cfg_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    tick_if.producer  tk
);

    prescaler_state_t s_r;
    prescaler_state_t s_nxt;

    // Count down from the divider; one tick every divider+1 cycles
    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt == 16'h0000) begin
            s_nxt.cnt  = tk.divider;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt  = s_r.cnt - 16'h0001;
            s_nxt.tick = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{cnt: TICK_DIV_RST, tick: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tk.tick = s_r.tick;

    // Helper: cycles since last tick, and whether the divider moved meanwhile
    logic [16:0] gap_q;
    logic        seen_q;
    logic        chg_q;
    logic [15:0] prev_div_q;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_q      <= 17'h00000;
            seen_q     <= 1'b0;
            chg_q      <= 1'b1;
            prev_div_q <= 16'h0000;
        end else begin
            prev_div_q <= tk.divider;
            if (s_r.tick) begin
                gap_q  <= 17'h00001;
                seen_q <= 1'b1;
                // A divider change on the load edge still spoils the next spacing
                chg_q  <= (tk.divider != prev_div_q);
            end else begin
                gap_q <= gap_q + 17'h00001;
                chg_q <= chg_q | (tk.divider != prev_div_q);
            end
        end
    end

    property p_tick_period;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (s_r.tick && seen_q && !chg_q && (tk.divider == prev_div_q)) |-> (gap_q == ({1'b0, tk.divider} + 17'h00001));
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick spacing differs from divider+1");

endmodule : tick_prescaler
